// File: sysopt_pkg.sv
// Package with the register map, field layout, reset values and identity of the option bank.
package sysopt_pkg;

  // ********************************************************************
  // Register byte addresses on the APB bus
  // ********************************************************************
  localparam logic [7:0] ADDR_OPT_ONE = 8'h00;
  localparam logic [7:0] ADDR_OPT_TWO = 8'h04;
  localparam logic [7:0] ADDR_ID_HIGH = 8'h08;
  localparam logic [7:0] ADDR_ID_LOW = 8'h0C;

  // ********************************************************************
  // Field positions of the first options register
  // ********************************************************************
  localparam int OPT1_TIMEOUT_HI = 7;
  localparam int OPT1_TIMEOUT_LO = 6;
  localparam int OPT1_STOP = 5;
  localparam int OPT1_TWOWIRE = 2;
  localparam int OPT1_DEBUG = 1;
  localparam int OPT1_RESETPIN = 0;

  // ********************************************************************
  // Field positions of the second options register
  // ********************************************************************
  localparam int OPT2_WDCLK = 7;
  localparam int OPT2_WINDOW = 6;
  localparam int OPT2_CMPCAP = 4;
  localparam int OPT2_T2CH1 = 3;
  localparam int OPT2_T2CH0 = 2;
  localparam int OPT2_T1CH1 = 1;
  localparam int OPT2_T1CH0 = 0;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [1:0] TIMEOUT_RST_OTHER = 2'h3;
  localparam logic [1:0] TIMEOUT_RST_POWER = 2'h2;
  localparam logic [7:0] OPT2_RST = 8'h00;

  // ********************************************************************
  // Identification and watchdog window figures
  // ********************************************************************
  localparam logic [11:0] PART_ID_DEFAULT = 12'h5C3;
  localparam int WDOG_CNT_W = 18;
  localparam logic [1:0] WINDOW_EARLY_PARTS = 2'h3;
  localparam logic [2:0] WINDOW_ALL_PARTS = 3'h4;

endpackage

// File: sysopt_regs.sv
// System option and part identification register bank with APB slave and pin routing.
//
// Function
// - First options register takes only first write
// - Timeout field plus clock select sets period
// - Stop allowed, else stop gives illegal-opcode reset
// - Two-wire pins on port A or B
// - Debug pin debug function or output-only alternative
// - Debug pin enable returns to one always
// - Reset pin enable gives external reset function
// - Power-on reset clears reset pin enable
// - Reset pin enable survives non-power-on resets
// - Pull-up on while reset pin enabled
// - Watchdog clock 1 kHz or bus clock
// - Early service write in window resets device
// - Window mode only with bus clock source
// - Write-once second register bits take one write
// - Comparator routed to first timer capture zero
// - Second timer channel 1 pin select
// - Second timer channel 0 pin select
// - First timer channel 1 pin select
// - First timer channel 0 pin select
// - Hard-wired 12-bit part identifier split over two
// - High ident bit 7 zero, writes ignored
//
// Chosen here: the register addresses and the APB register port.
module sysopt_regs
  import sysopt_pkg::*;
#(
  parameter logic [11:0] PART_ID = PART_ID_DEFAULT // Arbitrary neutral value.
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic RST_SRC_POR,
  input wire logic RST_SRC_LVR,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Watchdog control and window check
  output logic [1:0] WDOG_TIMEOUT_SEL,
  output logic WDOG_CLK_SEL,
  output logic WDOG_WINDOW_ACTIVE,
  input wire logic SERVICE_REG_WRITE,
  input wire logic [17:0] WDOG_ELAPSED,
  input wire logic [17:0] WDOG_PERIOD,
  output logic WDOG_WINDOW_RST,
  // Stop instruction handling
  input wire logic STOP_ATTEMPT,
  output logic STOP_ENTER,
  output logic ILLEGAL_OP_RST,
  // Two-wire pin placement
  output logic TWOWIRE_ON_PORTA,
  output logic TWOWIRE_ON_PORTB,
  // Shared debug pin
  input wire logic DBG_GPIO_OUT,
  input wire logic DBG_CMP_OUT_EN,
  output logic DEBUG_PIN_FUNC,
  output logic DEBUG_PIN_OUT,
  // Shared reset pin
  output logic RESET_PIN_FUNC,
  output logic RESET_PIN_PULLUP,
  // Comparator to timer capture
  input wire logic CMP_OUT,
  input wire logic TIMER1_CH0_PIN_IN,
  output logic TIMER1_CH0_CAPTURE,
  // Timer channel pin selects
  output logic TIMER2_CH1_ON_PTA7,
  output logic TIMER2_CH0_ON_PTA6,
  output logic TIMER1_CH1_ON_PTC1,
  output logic TIMER1_CH0_ON_PTC0
);

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  logic sel_opt1, sel_opt2, sel_idh, sel_idl, mapped, wr_access, wr_byte;
  logic [7:0] wr_data;

  // Address decode and the write strobe taken in the access phase.
  assign sel_opt1 = (PADDR == ADDR_OPT_ONE);
  assign sel_opt2 = (PADDR == ADDR_OPT_TWO);
  assign sel_idh = (PADDR == ADDR_ID_HIGH);
  assign sel_idl = (PADDR == ADDR_ID_LOW);
  assign mapped = sel_opt1 | sel_opt2 | sel_idh | sel_idl;
  assign wr_access = PSEL & PENABLE & PWRITE;
  assign wr_byte = wr_access & PSTRB[0];
  assign wr_data = PWDATA[7:0];

  // The slave answers in the first access cycle; unmapped addresses report an error.
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // ********************************************************************
  // First options register
  // ********************************************************************
  logic [1:0] timeout_ff;
  logic stop_ff;
  logic twowire_ff;
  logic debug_en_ff;
  logic reset_pin_ff;
  logic opt1_locked_ff;
  logic opt1_take;

  // Only the first write after any reset lands.
  assign opt1_take = wr_byte & sel_opt1 & ~opt1_locked_ff;

  // Lock flag for the whole first register, cleared by every reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      opt1_locked_ff <= 1'b0;
    else if (wr_byte && sel_opt1)
      opt1_locked_ff <= 1'b1;
  end

  // Timeout, stop, two-wire and debug fields: reset on every kind of reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      if (RST_SRC_POR || RST_SRC_LVR)
        timeout_ff <= TIMEOUT_RST_POWER;
      else
        timeout_ff <= TIMEOUT_RST_OTHER;
      stop_ff <= 1'b0;
      twowire_ff <= 1'b0;
      debug_en_ff <= 1'b1;
    end
    else if (opt1_take)
    begin
      timeout_ff <= wr_data[OPT1_TIMEOUT_HI:OPT1_TIMEOUT_LO];
      stop_ff <= wr_data[OPT1_STOP];
      twowire_ff <= wr_data[OPT1_TWOWIRE];
      debug_en_ff <= wr_data[OPT1_DEBUG];
    end
  end

  // Reset pin enable: only power-on clears it, other resets leave it alone.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      if (RST_SRC_POR)
        reset_pin_ff <= 1'b0;
    end
    else if (opt1_take)
      reset_pin_ff <= wr_data[OPT1_RESETPIN];
  end

  // ********************************************************************
  // Second options register
  // ********************************************************************
  logic wdclk_ff;
  logic window_ff;
  logic opt2_locked_ff;
  logic [4:0] opt2_plain_ff;
  logic opt2_wr;

  assign opt2_wr = wr_byte & sel_opt2;

  // Watchdog clock and window bits take one write after reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      wdclk_ff <= OPT2_RST[OPT2_WDCLK];
      window_ff <= OPT2_RST[OPT2_WINDOW];
      opt2_locked_ff <= 1'b0;
    end
    else if (opt2_wr && !opt2_locked_ff)
    begin
      wdclk_ff <= wr_data[OPT2_WDCLK];
      window_ff <= wr_data[OPT2_WINDOW];
      opt2_locked_ff <= 1'b1;
    end
  end

  // Routing bits stay freely writable.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      opt2_plain_ff <= OPT2_RST[OPT2_CMPCAP:OPT2_T1CH0];
    else if (opt2_wr)
      opt2_plain_ff <= wr_data[OPT2_CMPCAP:OPT2_T1CH0];
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [7:0] opt1_view;
  logic [7:0] opt2_view;
  logic [7:0] idh_view;
  logic [7:0] idl_view;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  // Register views; unimplemented bits read zero.
  always_comb
  begin
    opt1_view = 8'h00;
    opt1_view[OPT1_TIMEOUT_HI:OPT1_TIMEOUT_LO] = timeout_ff;
    opt1_view[OPT1_STOP] = stop_ff;
    opt1_view[OPT1_TWOWIRE] = twowire_ff;
    opt1_view[OPT1_DEBUG] = debug_en_ff;
    opt1_view[OPT1_RESETPIN] = reset_pin_ff;
    opt2_view = 8'h00;
    opt2_view[OPT2_WDCLK] = wdclk_ff;
    opt2_view[OPT2_WINDOW] = window_ff;
    opt2_view[OPT2_CMPCAP:OPT2_T1CH0] = opt2_plain_ff;
    idh_view = {4'h0, PART_ID[11:8]};
    idl_view = PART_ID[7:0];
  end

  // Read mux; identification registers have no write path at all.
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (sel_opt1)
      nxt_rdata[7:0] = opt1_view;
    else if (sel_opt2)
      nxt_rdata[7:0] = opt2_view;
    else if (sel_idh)
      nxt_rdata[7:0] = idh_view;
    else if (sel_idl)
      nxt_rdata[7:0] = idl_view;
  end

  // Read data is captured in the setup cycle so it stands through the access cycle.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      rdata_ff <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      rdata_ff <= nxt_rdata;
  end

  assign PRDATA = rdata_ff;

  // ********************************************************************
  // Watchdog window check
  // ********************************************************************
  logic window_active, early_phase, window_rst_ff;
  logic [20:0] early_lhs, early_rhs;

  // Window mode needs the bus clock as watchdog source.
  assign window_active = window_ff & wdclk_ff;

  // Elapsed time below three quarters of the period is the forbidden phase.
  assign early_lhs = 21'(WDOG_ELAPSED) * 21'(WINDOW_ALL_PARTS);
  assign early_rhs = 21'(WDOG_PERIOD) * 21'(WINDOW_EARLY_PARTS);
  assign early_phase = (early_lhs < early_rhs);

  // A service-register write in the early phase requests a reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      window_rst_ff <= 1'b0;
    else
      window_rst_ff <= window_active & SERVICE_REG_WRITE & early_phase;
  end

  // ********************************************************************
  // Stop instruction and pin routing
  // ********************************************************************
  logic stop_enter_ff, illegal_op_ff, debug_out_ff, capture_ff;

  // Stop attempts either enter stop or force an illegal-opcode reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      stop_enter_ff <= 1'b0;
      illegal_op_ff <= 1'b0;
    end
    else
    begin
      stop_enter_ff <= STOP_ATTEMPT & stop_ff;
      illegal_op_ff <= STOP_ATTEMPT & ~stop_ff;
    end
  end

  // Output-only alternative on the debug pin and the capture source of timer one.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      debug_out_ff <= 1'b0;
      capture_ff <= 1'b0;
    end
    else
    begin
      debug_out_ff <= DBG_CMP_OUT_EN ? CMP_OUT : DBG_GPIO_OUT;
      capture_ff <= opt2_plain_ff[OPT2_CMPCAP] ? CMP_OUT : TIMER1_CH0_PIN_IN;
    end
  end

  // Outputs driven from the option flip-flops and the registered window, stop and pin results.
  assign WDOG_TIMEOUT_SEL = timeout_ff;
  assign WDOG_CLK_SEL = wdclk_ff;
  assign WDOG_WINDOW_ACTIVE = window_active;
  assign WDOG_WINDOW_RST = window_rst_ff;
  assign STOP_ENTER = stop_enter_ff;
  assign ILLEGAL_OP_RST = illegal_op_ff;
  assign TWOWIRE_ON_PORTA = ~twowire_ff;
  assign TWOWIRE_ON_PORTB = twowire_ff;
  assign DEBUG_PIN_FUNC = debug_en_ff;
  assign DEBUG_PIN_OUT = debug_out_ff;
  assign RESET_PIN_FUNC = reset_pin_ff;
  assign RESET_PIN_PULLUP = reset_pin_ff;
  assign TIMER1_CH0_CAPTURE = capture_ff;
  assign TIMER2_CH1_ON_PTA7 = opt2_plain_ff[OPT2_T2CH1];
  assign TIMER2_CH0_ON_PTA6 = opt2_plain_ff[OPT2_T2CH0];
  assign TIMER1_CH1_ON_PTC1 = opt2_plain_ff[OPT2_T1CH1];
  assign TIMER1_CH0_ON_PTC0 = opt2_plain_ff[OPT2_T1CH0];

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // A second write to the first register leaves it unchanged.
  sequence opt1_second_write;
    wr_byte && sel_opt1 && opt1_locked_ff;
  endsequence
  sequence opt2_second_write;
    opt2_wr && opt2_locked_ff;
  endsequence
  opt1_once_a: assert property (opt1_second_write |=> $stable(opt1_view))
    else $error("First options register changed on a later write.");
  opt1_first_a: assert property (opt1_take |=> opt1_view ==
      {$past(wr_data[7:5]), 2'h0, $past(wr_data[2:0])} ##1 opt1_locked_ff)
    else $error("First write to the first options register not stored.");
  opt2_once_a: assert property (opt2_second_write |=> $stable({wdclk_ff, window_ff}))
    else $error("Write-once watchdog bits changed on a later write.");
  stop_path_a: assert property (STOP_ATTEMPT |=> (ILLEGAL_OP_RST == !$past(stop_ff))
      && (STOP_ENTER == $past(stop_ff)))
    else $error("Stop attempt handled against the stop enable.");
  window_rst_a: assert property (SERVICE_REG_WRITE && window_active && early_phase
      |=> WDOG_WINDOW_RST)
    else $error("Early service write in window mode gave no reset.");
  window_clk_a: assert property (!wdclk_ff |-> !WDOG_WINDOW_ACTIVE ##1 !WDOG_WINDOW_RST)
    else $error("Window check active without bus clock source.");
  pullup_pin_a: assert property (RESET_PIN_PULLUP == RESET_PIN_FUNC)
    else $error("Reset pin pull-up differs from reset pin function.");
  ident_read_a: assert property (PSEL && !PENABLE && !PWRITE && sel_idh
      |=> PRDATA == {24'h0, 4'h0, PART_ID[11:8]})
    else $error("High identification read wrong.");
  cmp_route_a: assert property (opt2_plain_ff[OPT2_CMPCAP]
      |=> TIMER1_CH0_CAPTURE == $past(CMP_OUT))
    else $error("Comparator not routed to timer capture.");
  reset_keep_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
      !RST_N && !RST_SRC_POR |=> $stable(reset_pin_ff))
    else $error("Reset pin enable lost on a non-power-on reset.");
  debug_reset_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
      !RST_N |=> DEBUG_PIN_FUNC)
    else $error("Debug pin enable not set after reset.");

endmodule

// File: sysopt_regs_tb.sv
// Self-checking testbench for the system option and identification register bank.
`define check_eq(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module sysopt_regs_tb
  import sysopt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************************
  // Signals
  // ********************************************************************
  localparam logic [11:0] ID_VAL = 12'hA5E; // Arbitrary value.
  logic clk_sys, rst_n, rst_src_por, rst_src_lvr, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] wd_tsel;
  logic [17:0] elapsed, period;
  logic wd_clk, wd_win, wd_win_rst, svc_wr, stop_try, stop_enter, ill_rst, err;
  logic tw_a, tw_b, gpio_out, cmp_en, dbg_func, dbg_out, rst_func, rst_pull;
  logic cmp_out, pin_in, cap, t2c1, t2c0, t1c1, t1c0;
  int num_errors = 0;
  int total_checks = 0;

  // ********************************************************************
  // Design under test
  // ********************************************************************
  sysopt_regs #(.PART_ID(ID_VAL)) dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .RST_SRC_POR(rst_src_por), .RST_SRC_LVR(rst_src_lvr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .WDOG_TIMEOUT_SEL(wd_tsel), .WDOG_CLK_SEL(wd_clk), .WDOG_WINDOW_ACTIVE(wd_win),
    .SERVICE_REG_WRITE(svc_wr), .WDOG_ELAPSED(elapsed), .WDOG_PERIOD(period),
    .WDOG_WINDOW_RST(wd_win_rst), .STOP_ATTEMPT(stop_try), .STOP_ENTER(stop_enter),
    .ILLEGAL_OP_RST(ill_rst), .TWOWIRE_ON_PORTA(tw_a), .TWOWIRE_ON_PORTB(tw_b),
    .DBG_GPIO_OUT(gpio_out), .DBG_CMP_OUT_EN(cmp_en), .DEBUG_PIN_FUNC(dbg_func),
    .DEBUG_PIN_OUT(dbg_out), .RESET_PIN_FUNC(rst_func), .RESET_PIN_PULLUP(rst_pull),
    .CMP_OUT(cmp_out), .TIMER1_CH0_PIN_IN(pin_in), .TIMER1_CH0_CAPTURE(cap),
    .TIMER2_CH1_ON_PTA7(t2c1), .TIMER2_CH0_ON_PTA6(t2c0), .TIMER1_CH1_ON_PTC1(t1c1),
    .TIMER1_CH0_ON_PTC0(t1c0)
  );

  // Free-running 40 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      $display("mismatch at %0t: no ready from the slave", $time);
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Reads a register and compares its byte, with no error response.
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'h0);
    `check_eq(rd, {24'h000000, exp})
    `check_eq(err, 1'b0)
  endtask

  // One-cycle pulse on the stop and service strobes; returns once the answer cycle settled.
  task automatic strobe(input logic st, input logic sv);
    @(posedge clk_sys);
    stop_try <= st;
    svc_wr <= sv;
    @(posedge clk_sys);
    stop_try <= 1'b0;
    svc_wr <= 1'b0;
    #1;
  endtask

  // Service write at a given elapsed count of a 100-tick period.
  task automatic svc(input logic [17:0] e, input logic exp);
    @(posedge clk_sys);
    elapsed <= e;
    strobe(1'b0, 1'b1);
    `check_eq(wd_win_rst, exp)
  endtask

  // Drives the shared pin inputs and waits for the registered outputs.
  task automatic pins(input logic g, input logic ce, input logic c, input logic p);
    @(posedge clk_sys);
    gpio_out <= g;
    cmp_en <= ce;
    cmp_out <= c;
    pin_in <= p;
    @(posedge clk_sys);
    #1;
  endtask

  // Applies a reset of the given source, held for 12 cycles.
  task automatic do_reset(input logic por, input logic low_voltage_reset);
    @(posedge clk_sys);
    rst_src_por <= por;
    rst_src_lvr <= low_voltage_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    {rst_n, rst_src_por, rst_src_lvr, psel, penable, pwrite} = 6'b010000;
    {paddr, pwdata, pstrb} = 44'h0;
    {svc_wr, stop_try, gpio_out, cmp_en, cmp_out, pin_in} = 6'h00;
    elapsed = 18'h00000;
    period = 18'h00064;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk_rd(ADDR_OPT_ONE, 8'h82);
    chk_rd(ADDR_OPT_TWO, 8'h00);
    `check_eq({wd_tsel, tw_a, tw_b, dbg_func, rst_func, rst_pull}, 7'b1010100)
    chk_rd(ADDR_ID_HIGH, {4'h0, ID_VAL[11:8]});
    chk_rd(ADDR_ID_LOW, ID_VAL[7:0]);
    apb(1'b1, ADDR_ID_HIGH, 8'hFF, 4'hF);
    apb(1'b1, ADDR_ID_LOW, 8'hFF, 4'hF);
    chk_rd(ADDR_ID_HIGH, {4'h0, ID_VAL[11:8]});
    chk_rd(ADDR_ID_LOW, ID_VAL[7:0]);
    apb(1'b0, 8'h10, 8'h00, 4'h0);
    `check_eq({err, rd}, {1'b1, 32'h00000000})
    strobe(1'b1, 1'b0);
    `check_eq({stop_enter, ill_rst}, 2'b01)
    apb(1'b1, ADDR_OPT_TWO, 8'h40, 4'hF);
    `check_eq({wd_clk, wd_win}, 2'b00)
    svc(18'h0000A, 1'b0);
    apb(1'b1, ADDR_OPT_ONE, 8'h3D, 4'h0);
    chk_rd(ADDR_OPT_ONE, 8'h82);
    apb(1'b1, ADDR_OPT_ONE, 8'h3D, 4'hF);
    chk_rd(ADDR_OPT_ONE, 8'h25);
    `check_eq({wd_tsel, tw_a, tw_b, dbg_func, rst_func, rst_pull}, 7'b0001011)
    apb(1'b1, ADDR_OPT_ONE, 8'hC2, 4'hF);
    chk_rd(ADDR_OPT_ONE, 8'h25);
    strobe(1'b1, 1'b0);
    `check_eq({stop_enter, ill_rst}, 2'b10)
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    `check_eq(dbg_out, 1'b1)
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    `check_eq({dbg_out, cap}, 2'b10)
    do_reset(1'b0, 1'b0);
    chk_rd(ADDR_OPT_ONE, 8'hC3);
    `check_eq({rst_func, rst_pull}, 2'b11)
    chk_rd(ADDR_OPT_TWO, 8'h00);
    apb(1'b1, ADDR_OPT_TWO, 8'hDF, 4'hF);
    chk_rd(ADDR_OPT_TWO, 8'hDF);
    `check_eq({wd_clk, wd_win, t2c1, t2c0, t1c1, t1c0}, 6'h3F)
    svc(18'h0000A, 1'b1);
    svc(18'h0004A, 1'b1);
    svc(18'h0004B, 1'b0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    `check_eq(cap, 1'b1)
    apb(1'b1, ADDR_OPT_TWO, 8'h00, 4'hF);
    chk_rd(ADDR_OPT_TWO, 8'hC0);
    `check_eq({wd_clk, wd_win, t2c1, t2c0, t1c1, t1c0}, 6'h30)
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    `check_eq(cap, 1'b0)
    do_reset(1'b0, 1'b1);
    chk_rd(ADDR_OPT_ONE, 8'h83);
    do_reset(1'b1, 1'b0);
    chk_rd(ADDR_OPT_ONE, 8'h82);
    close_out();
  end
endmodule
